// ==== logic/dfir_top.sv ====
// dfir_top: dual symmetric fir with decimation, lifo reversal and rounding.
// assumes sample and control pins synchronous to clk; the write strobe may
// be asynchronous and must be held low and high for at least 3 clocks.
`timescale 1ns/100ps
`default_nettype none
module dfir_top #(
  parameter int DW = dfir_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [DW-1:0] sample_in_a,
  input wire logic [DW-1:0] sample_in_b,
  input wire logic cfg_write_n,
  input wire logic [dfir_pkg::ADDR_W-1:0] cfg_write_addr,
  input wire logic [DW-1:0] cfg_write_data,
  input wire logic [dfir_pkg::SET_W-1:0] coef_set_select,
  input wire logic sample_hold_n,
  input wire logic forward_zero_sel,
  input wire logic reverse_zero_sel_n,
  input wire logic lifo_swap,
  input wire logic accumulate_on,
  input wire logic [1:0] combine_select,
  input wire logic low_out_enable_n,
  input wire logic high_out_enable_n,
  output logic [dfir_pkg::RES_W-1:0] result_out,
  output logic result_low_oe,
  output logic result_high_oe
);

  dfir_pkg::dfir_state_t s_r;
  dfir_pkg::dfir_state_t s_nxt;

  logic wr_fall;
  logic wr_rise;
  logic int_rst;
  logic swap_evt;
  logic [DW-1:0] b_pin;
  logic [1:0][DW-1:0] din;
  logic [1:0][DW-1:0] fwd;
  logic [1:0][DW-1:0] rev;
  logic [1:0] dtc;
  logic [1:0] ctc;
  logic [11:0] aop;
  logic [11:0] bop;
  logic signed [11:0] alu;
  logic signed [10:0] cx;
  logic signed [22:0] prod;
  logic [dfir_pkg::RES_W-1:0] pext;
  logic [dfir_pkg::RES_W-1:0] cmb;
  logic [dfir_pkg::RES_W-1:0] rnd;
  logic [dfir_pkg::RES_W-1:0] half;
  logic [dfir_pkg::RES_W-1:0] mask;
  logic [4:0] rw;
  logic [4:0] drop;
  logic [dfir_pkg::TAP_W-1:0] tap_nxt;
  logic [DW-1:0] coef;

  // ***************************************************************
  // coefficient store
  // ***************************************************************
  // read address looks one tap ahead so the registered read lines up
  assign tap_nxt = s_r.acc_on ? s_r.tap + 3'h1 : 3'h0;

  dfir_coef_mem #(
    .AW(dfir_pkg::MEM_AW),
    .DW(DW)
  ) u_coef (
    .clk(clk),
    .rst(rst),
    .we(s_r.mem_we),
    .waddr(s_r.mem_addr),
    .wdata(s_r.mem_data),
    .raddr({s_r.set, tap_nxt}),
    .rdata(coef)
  );

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  always_comb begin
    s_nxt = s_r;
    din = '0;
    fwd = '0;
    rev = '0;
    dtc = '0;
    ctc = '0;
    aop = '0;
    bop = '0;
    alu = '0;
    cx = '0;
    prod = '0;
    pext = '0;
    cmb = '0;
    rnd = '0;
    half = '0;
    mask = '0;
    rw = '0;
    drop = '0;

    // strobe synchroniser, stored active high; only s2 and s3 are looked at
    s_nxt.wr_s1 = ~cfg_write_n;
    s_nxt.wr_s2 = s_r.wr_s1;
    s_nxt.wr_s3 = s_r.wr_s2;
    wr_fall = s_r.wr_s2 & ~s_r.wr_s3;
    wr_rise = ~s_r.wr_s2 & s_r.wr_s3;
    int_rst = s_r.rst_cnt != 3'h0;

    // internal reset countdown, reloaded by every config write
    if (int_rst) begin
      s_nxt.rst_cnt = s_r.rst_cnt - 3'h1;
    end

    // configuration port: address on the low edge, data on the high edge
    s_nxt.mem_we = 1'b0;
    case (s_r.cp)
      dfir_pkg::CP_IDLE: begin
        if (wr_fall) begin
          s_nxt.addr = cfg_write_addr;
          s_nxt.cp = dfir_pkg::CP_ADDR;
        end
      end
      dfir_pkg::CP_ADDR: begin
        if (wr_rise) begin
          s_nxt.cp = dfir_pkg::CP_IDLE;
          if (s_r.addr == dfir_pkg::ADDR_CFG0) begin
            s_nxt.cfg0 = cfg_write_data;
            s_nxt.rst_cnt = dfir_pkg::INT_RST_CNT;
          end else if (s_r.addr == dfir_pkg::ADDR_CFG1) begin
            s_nxt.cfg1 = cfg_write_data;
            s_nxt.rst_cnt = dfir_pkg::INT_RST_CNT;
          end else if (s_r.addr[dfir_pkg::COEF_SEL_BIT]) begin
            s_nxt.mem_we = 1'b1;
            s_nxt.mem_addr = s_r.addr[dfir_pkg::MEM_AW-1:0];
            s_nxt.mem_data = cfg_write_data;
          end
          // reserved addresses are dropped with no side effect
        end
      end
      default: begin
        s_nxt.cp = dfir_pkg::CP_IDLE;
      end
    endcase

    // control pins, each through one register stage
    s_nxt.hold = sample_hold_n;
    s_nxt.fz = forward_zero_sel;
    s_nxt.rzn = reverse_zero_sel_n;
    s_nxt.swap = lifo_swap;
    s_nxt.swap_prev = s_r.swap;
    s_nxt.acc_on = accumulate_on;
    s_nxt.cmb = combine_select;
    s_nxt.set = coef_set_select;
    s_nxt.oe_lo = ~low_out_enable_n;
    s_nxt.oe_hi = ~high_out_enable_n;
    s_nxt.tap = tap_nxt;
    swap_evt = s_r.swap_prev & ~s_r.swap;
    if (swap_evt) begin
      s_nxt.fill = ~s_r.fill;
    end

    // shared pins carry only b bit 0 while the low output half drives them
    b_pin = s_r.oe_lo ? {9'h000, sample_in_b[0]} : sample_in_b;

    // forward path taps the delay line at the programmed length
    fwd[0] = s_r.f[0].dly[s_r.cfg0.decim];
    fwd[1] = s_r.f[1].dly[s_r.cfg0.decim];
    din[0] = sample_in_a;
    if (!s_r.cfg0.dual) begin
      din[1] = fwd[0];
    end else if (s_r.cfg0.b_src_pin_b) begin
      din[1] = b_pin;
    end else begin
      din[1] = sample_in_a;
    end
    dtc = {s_r.cfg1.b_data_tc, s_r.cfg1.a_data_tc};
    ctc = {s_r.cfg1.b_coef_tc, s_r.cfg1.a_coef_tc};

    // ***************************************************************
    // per-filter datapath
    // ***************************************************************
    for (int i = 0; i < 2; i++) begin
      // reversal off means the reverse path sees the forward samples
      if (s_r.cfg1.reverse_en) begin
        rev[i] = s_r.f[i].lifo[~s_r.fill][s_r.f[i].rptr];
      end else begin
        rev[i] = fwd[i];
      end

      // hold freezes input, delay line and lifo pointers together
      if (!s_r.hold) begin
        s_nxt.f[i].din = din[i];
        s_nxt.f[i].dly = {s_r.f[i].dly[dfir_pkg::DLY_MAX-2:0], s_r.f[i].din};
        s_nxt.f[i].lifo[s_r.fill][s_r.f[i].wptr] = fwd[i];
        s_nxt.f[i].wptr = s_r.f[i].wptr + 4'h1;
        s_nxt.f[i].rptr = s_r.f[i].rptr - 4'h1;
      end
      // on a swap the freshly filled lifo is read back newest first
      if (swap_evt) begin
        s_nxt.f[i].wptr = '0;
        s_nxt.f[i].rptr = s_r.f[i].wptr - 4'h1;
      end

      // symmetric pre-add with per-filter operand formats
      aop = s_r.fz ? 12'h000 : {{2{dtc[i] & fwd[i][DW-1]}}, fwd[i]};
      bop = s_r.rzn ? 12'h000 : {{2{dtc[i] & rev[i][DW-1]}}, rev[i]};
      alu = s_r.cfg0.odd_sym ? aop - bop : aop + bop;
      cx = {ctc[i] & coef[DW-1], coef};
      prod = alu * cx;
      pext = {{5{prod[22]}}, prod};

      // accumulate low dumps the sum to the output and restarts it with the current product
      if (s_r.acc_on) begin
        s_nxt.f[i].acc = s_r.f[i].acc + pext;
      end else begin
        s_nxt.f[i].res = s_r.f[i].acc;
        s_nxt.f[i].acc = pext;
      end
    end

    // ***************************************************************
    // combine, round, output
    // ***************************************************************
    case (s_r.cmb)
      dfir_pkg::CMB_A: cmb = s_r.f[0].res;
      dfir_pkg::CMB_B: cmb = s_r.f[1].res;
      dfir_pkg::CMB_SUM: cmb = s_r.f[0].res + s_r.f[1].res;
      dfir_pkg::CMB_DIFF: cmb = s_r.f[0].res - s_r.f[1].res;
      default: cmb = s_r.f[0].res;
    endcase

    // round half up at the kept width; overflow at full scale wraps
    rw = dfir_pkg::RND_MIN_W + {1'b0, s_r.cfg1.round_pos};
    if (rw > dfir_pkg::RND_MAX_W) begin
      rw = dfir_pkg::RND_MAX_W;
    end
    drop = dfir_pkg::RES_W5 - rw;
    half = 28'h0000001 << (drop - 5'h01);
    mask = ~((28'h0000001 << drop) - 28'h0000001);
    if (s_r.cfg1.round_en) begin
      rnd = (cmb + half) & mask;
    end else begin
      rnd = cmb;
    end
    s_nxt.result = rnd;

    // internal reset clears the datapath but spares the coefficients
    if (int_rst) begin
      s_nxt.f = '0;
      s_nxt.fill = 1'b0;
      s_nxt.result = '0;
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // single clocked process; everything moves on the rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= dfir_pkg::STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************************
  // pins
  // ***************************************************************
  // enables are high while driving; nothing in the bench resolves the shared pins
  assign result_out = s_r.result;
  assign result_low_oe = s_r.oe_lo;
  assign result_high_oe = s_r.oe_hi;

endmodule : dfir_top
`default_nettype wire

// ==== logic/dfir_pkg.sv ====
// dfir_pkg: constants, register layouts and state types for the dual fir block.
// assumes one 50 MHz master clock and a write-only configuration port.
// How it works
// - all registers move on rising clk only
// - filter a input registered, may feed b
// - b input upper bits shared with output
// - address at strobe fall, data at rise
// - registered five-bit set select picks coefficients
// - registered 28-bit result, signed unless all unsigned
// - hold control freezes inputs and decimation registers
// - forward control zeroes alu first operand
// - reverse control zeroes alu second operand
// - swap lifos only on high-to-low swap control
// - accumulate holds outputs, low reloads and restarts
// - two-bit select combines the two results
// - low enable drives low bits, blocks b input bits 9 to 1
// - high enable drives bits 27 down to 9
// - config at 000h and 001h, coefficients at 100h up, rest reserved
// - config write gives six-cycle reset, coefficients kept
// - config writes need no clock relationship
// - decimation up to sixteen to one
// - samples and coefficients signed or unsigned each
// - symmetric pre-add, cascade gives longer filter
// - each set holds eight independent coefficients
// - optional rounding to 8 through 19 bits
// - low nibble n gives delay n plus one
// - bit 4 selects cascaded or dual filters
package dfir_pkg;

  // ***************************************************************
  // widths and sizes
  // ***************************************************************
  localparam int DATA_W = 10;
  localparam int ADDR_W = 9;
  localparam int RES_W = 28;
  localparam int SET_W = 5;
  localparam int TAP_W = 3;
  localparam int MEM_AW = SET_W + TAP_W;
  localparam int DLY_MAX = 16;
  localparam int PTR_W = 4;

  // ***************************************************************
  // configuration port map
  // ***************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CFG0 = 9'h000;
  localparam logic [ADDR_W-1:0] ADDR_CFG1 = 9'h001;
  localparam int COEF_SEL_BIT = 8; // address bit that picks coefficient space
  localparam logic [2:0] INT_RST_CNT = 3'h6; // internal reset length in clocks

  // ***************************************************************
  // rounding and combine encodings
  // ***************************************************************
  localparam logic [4:0] RND_MIN_W = 5'h08;
  localparam logic [4:0] RND_MAX_W = 5'h13;
  localparam logic [4:0] RES_W5 = 5'h1c;
  localparam logic [1:0] CMB_A = 2'h0;
  localparam logic [1:0] CMB_B = 2'h1;
  localparam logic [1:0] CMB_SUM = 2'h2;
  localparam logic [1:0] CMB_DIFF = 2'h3;

  // ***************************************************************
  // register layouts
  // ***************************************************************
  typedef struct packed {
    logic interleave;
    logic b_src_pin_b;
    logic b_even_taps;
    logic a_even_taps;
    logic odd_sym;
    logic dual;
    logic [3:0] decim;
  } dfir_cfg0_t;

  typedef struct packed {
    logic round_en;
    logic [3:0] round_pos;
    logic reverse_en;
    logic b_coef_tc;
    logic b_data_tc;
    logic a_coef_tc;
    logic a_data_tc;
  } dfir_cfg1_t;

  typedef enum logic [0:0] {
    CP_IDLE = 1'b0,
    CP_ADDR = 1'b1
  } dfir_cp_t;

  typedef struct packed {
    logic [DATA_W-1:0] din;
    logic [DLY_MAX-1:0][DATA_W-1:0] dly;
    logic [1:0][DLY_MAX-1:0][DATA_W-1:0] lifo;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [RES_W-1:0] acc;
    logic [RES_W-1:0] res;
  } dfir_filt_t;

  typedef struct packed {
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    dfir_cp_t cp;
    logic [ADDR_W-1:0] addr;
    dfir_cfg0_t cfg0;
    dfir_cfg1_t cfg1;
    logic [2:0] rst_cnt;
    logic mem_we;
    logic [MEM_AW-1:0] mem_addr;
    logic [DATA_W-1:0] mem_data;
    logic hold;
    logic fz;
    logic rzn;
    logic swap;
    logic swap_prev;
    logic acc_on;
    logic [1:0] cmb;
    logic [SET_W-1:0] set;
    logic oe_lo;
    logic oe_hi;
    logic fill;
    logic [TAP_W-1:0] tap;
    logic [1:0] pad;
    dfir_filt_t [1:0] f;
    logic [RES_W-1:0] result;
  } dfir_state_t;

  // every flop, configuration included, clears to zero
  localparam dfir_state_t STATE_RESET = '0;

endpackage : dfir_pkg

// ==== logic/dfir_coef_mem.sv ====
// dfir_coef_mem: coefficient store, one write port and one registered read.
// assumes writes arrive already in the clk domain.
`timescale 1ns/100ps
`default_nettype none
module dfir_coef_mem #(
  parameter int AW = 8,
  parameter int DW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] rdata;
  } dfir_mem_state_t;

  dfir_mem_state_t s_r;
  dfir_mem_state_t s_nxt;

  // ***************************************************************
  // storage
  // ***************************************************************
  // read data always from a flop; a same-cycle write shows next read
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = s_r.mem[raddr];
    if (we) begin
      s_nxt.mem[waddr] = wdata;
    end
  end

  // only the hard reset clears the store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;

endmodule : dfir_coef_mem
`default_nettype wire

// ==== tb/dfir_top_props.sv ====
// dfir_top_props: concurrent checks on the dual fir pins.
// assumes only the ports of dfir_top; bound into every instance of it.
`timescale 1ns/100ps
`default_nettype none
module dfir_top_props #(
  parameter int DW = dfir_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [DW-1:0] sample_in_a,
  input wire logic [DW-1:0] sample_in_b,
  input wire logic cfg_write_n,
  input wire logic [dfir_pkg::ADDR_W-1:0] cfg_write_addr,
  input wire logic [DW-1:0] cfg_write_data,
  input wire logic [dfir_pkg::SET_W-1:0] coef_set_select,
  input wire logic sample_hold_n,
  input wire logic forward_zero_sel,
  input wire logic reverse_zero_sel_n,
  input wire logic lifo_swap,
  input wire logic accumulate_on,
  input wire logic [1:0] combine_select,
  input wire logic low_out_enable_n,
  input wire logic high_out_enable_n,
  input wire logic [dfir_pkg::RES_W-1:0] result_out,
  input wire logic result_low_oe,
  input wire logic result_high_oe
);
  // ***************************************************************
  // helper counters
  // ***************************************************************
  logic [8:0] last_addr_r;
  logic [3:0] cfg_cnt_r;
  logic [3:0] zero_cnt_r;
  logic [3:0] quiet_cnt_r;
  logic quiet;
  // counters saturate at 15 so they never wrap back under a threshold
  assign quiet = sample_hold_n && !accumulate_on;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_addr_r <= '0;
      cfg_cnt_r <= '0;
      zero_cnt_r <= '0;
      quiet_cnt_r <= '0;
    end else begin
      if (!cfg_write_n) last_addr_r <= cfg_write_addr; // class the coming rise
      cfg_cnt_r <= !cfg_write_n ? 4'h0 : (cfg_cnt_r == 4'hf ? cfg_cnt_r : cfg_cnt_r + 4'h1);
      if (forward_zero_sel && reverse_zero_sel_n && !accumulate_on)
        zero_cnt_r <= (zero_cnt_r == 4'hf) ? zero_cnt_r : zero_cnt_r + 4'h1;
      else zero_cnt_r <= '0;
      if (quiet && $stable(coef_set_select) && $stable(combine_select) &&
          $stable(forward_zero_sel) && $stable(reverse_zero_sel_n) && $stable(lifo_swap))
        quiet_cnt_r <= (quiet_cnt_r == 4'hf) ? quiet_cnt_r : quiet_cnt_r + 4'h1;
      else quiet_cnt_r <= '0;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  a_clear_after_reset: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> result_out == '0) else $error("result not clear after reset");
  a_oe_after_reset: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> !result_low_oe && !result_high_oe) else $error("enables set after reset");
  a_low_oe_follow: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> result_low_oe == !$past(low_out_enable_n)) else $error("low enable wrong");
  a_high_oe_follow: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> result_high_oe == !$past(high_out_enable_n)) else $error("high enable wrong");
  a_cfg_int_reset: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $rose(cfg_write_n) && last_addr_r[8:1] == '0
    |-> ##[3:4] (result_out == '0) [*4]) else $error("no internal reset after control write");
  a_accum_hold: assert property (@(posedge clk) disable iff (rst)
    cfg_cnt_r >= 4'hc && $past(accumulate_on, 1) && $past(accumulate_on, 2) &&
    $past(accumulate_on, 3) && $past(combine_select, 2) == $past(combine_select, 3)
    |-> $stable(result_out)) else $error("result moved while accumulating");
  a_operands_zero: assert property (@(posedge clk) disable iff (rst)
    zero_cnt_r >= 4'ha |-> result_out == '0) else $error("result not zero with operands zeroed");
  a_hold_stable: assert property (@(posedge clk) disable iff (rst)
    quiet_cnt_r >= 4'hc && cfg_cnt_r >= 4'hc |-> $stable(result_out))
    else $error("result moved while inputs held");
endmodule : dfir_top_props

bind dfir_top dfir_top_props #(.DW(DW)) i_dfir_top_props (.clk, .rst, .sample_in_a,
  .sample_in_b, .cfg_write_n, .cfg_write_addr, .cfg_write_data, .coef_set_select,
  .sample_hold_n, .forward_zero_sel, .reverse_zero_sel_n, .lifo_swap, .accumulate_on,
  .combine_select, .low_out_enable_n, .high_out_enable_n, .result_out, .result_low_oe,
  .result_high_oe);
`default_nettype wire

// ==== tb/dfir_host.sv ====
// dfir_host: coefficient and control loading host on the write-only port.
// assumes clk only as a time base; strobe edges sit 7 ns after it.
`timescale 1ns/100ps
`default_nettype none
module dfir_host (
  input wire logic clk,
  output logic cfg_write_n,
  output logic [dfir_pkg::ADDR_W-1:0] cfg_write_addr,
  output logic [dfir_pkg::DATA_W-1:0] cfg_write_data
);
  // ***************************************************************
  // write cycle
  // ***************************************************************
  initial begin
    cfg_write_n = 1'b1;
    cfg_write_addr = '0;
    cfg_write_data = '0;
  end
  // gap sets how long the strobe stays low, 3 is the shortest seen
  task automatic write(input logic [8:0] a, input logic [9:0] d, input int gap);
    @(posedge clk);
    #7; // off the clock, 7 ns after its rising edge
    cfg_write_addr = a; // address valid at the strobe fall
    cfg_write_data = d;
    cfg_write_n = 1'b0;
    repeat (gap) @(posedge clk);
    #7;
    cfg_write_n = 1'b1; // rise commits the data word
    repeat (4) @(posedge clk);
    #7;
    // released lines must not keep their last value
    cfg_write_addr = ~a;
    cfg_write_data = ~d;
    repeat (3) @(posedge clk);
  endtask : write
endmodule : dfir_host
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: directed scenarios for dfir_top with a host loading the port.
// assumes dfir_host as the loader and the bound property checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
  // ***************************************************************
  // signals and instances
  // ***************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] sample_in_a = '0;
  logic [9:0] sample_in_b = '0;
  logic [4:0] coef_set_select = '0;
  logic sample_hold_n = 1'b0;
  logic forward_zero_sel = 1'b0;
  logic reverse_zero_sel_n = 1'b1;
  logic lifo_swap = 1'b0;
  logic accumulate_on = 1'b0;
  logic [1:0] combine_select = '0;
  logic low_out_enable_n = 1'b1;
  logic high_out_enable_n = 1'b1;
  logic cfg_write_n;
  logic [8:0] cfg_write_addr;
  logic [9:0] cfg_write_data;
  logic [27:0] result_out;
  logic result_low_oe;
  logic result_high_oe;
  int n_errors = 0;
  int num_checks = 0;
  bit seen;
  logic [27:0] cmb_exp [4] = '{28'h000000f, 28'h000000f, 28'h000001e, 28'h0000000};
  always #10 clk = ~clk;
  dfir_top i_dfir_top (.clk, .rst, .sample_in_a, .sample_in_b, .cfg_write_n,
    .cfg_write_addr, .cfg_write_data, .coef_set_select, .sample_hold_n, .forward_zero_sel,
    .reverse_zero_sel_n, .lifo_swap, .accumulate_on, .combine_select, .low_out_enable_n,
    .high_out_enable_n, .result_out, .result_low_oe, .result_high_oe);
  dfir_host i_dfir_host (.clk, .cfg_write_n, .cfg_write_addr, .cfg_write_data);

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // watches a span for any cycle where the result reads zero
  task automatic watch_zero(output bit z);
    z = 1'b0;
    repeat (16) begin
      tick(1);
      if (result_out === 28'h0) z = 1'b1;
    end
  endtask : watch_zero
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_enables();
    for (int i = 0; i < 4; i++) begin
      {low_out_enable_n, high_out_enable_n} = i[1:0];
      tick(2);
      `CHK("low_oe", ~i[1], result_low_oe)
      `CHK("high_oe", ~i[0], result_high_oe)
    end
  endtask : t_enables
  // set 0 tap 0 = 3, set 1 tap 0 = 2, unsigned, dual filters fed from a
  task automatic t_setup();
    i_dfir_host.write(9'h100, 10'h003, 3);
    i_dfir_host.write(9'h108, 10'h002, 8);
    i_dfir_host.write(9'h001, 10'h000, 3);
    i_dfir_host.write(9'h000, 10'h010, 5);
    sample_in_a = 10'h005;
  endtask : t_setup
  task automatic t_combine();
    for (int i = 0; i < 4; i++) begin
      combine_select = i[1:0];
      tick(14);
      `CHK("combine", cmb_exp[i], result_out)
    end
    combine_select = 2'h0;
    coef_set_select = 5'h01;
    tick(14);
    `CHK("set1", 28'h000000a, result_out)
    coef_set_select = 5'h00;
  endtask : t_combine
  task automatic t_paths();
    forward_zero_sel = 1'b1;
    tick(14);
    `CHK("fwd_zero", 28'h0000000, result_out)
    reverse_zero_sel_n = 1'b0;
    // reversal on: the reverse side reads the cleared lifo until a swap
    i_dfir_host.write(9'h001, 10'h010, 3);
    tick(14);
    `CHK("no_swap", 28'h0000000, result_out)
    for (int k = 0; k < 2; k++) begin
      lifo_swap = 1'b1;
      tick(2);
      lifo_swap = 1'b0; // falling swap exchanges the lifos
      tick(20);
    end
    `CHK("reverse", 28'h000000f, result_out)
    reverse_zero_sel_n = 1'b1;
    forward_zero_sel = 1'b0;
    tick(14);
  endtask : t_paths
  task automatic t_hold_acc();
    sample_hold_n = 1'b1;
    tick(2);
    sample_in_a = 10'h007; // ignored while held
    tick(14);
    `CHK("held", 28'h000000f, result_out)
    sample_hold_n = 1'b0;
    tick(14);
    `CHK("released", 28'h0000015, result_out)
    accumulate_on = 1'b1;
    tick(2);
    sample_in_a = 10'h009;
    tick(14);
    `CHK("acc_hold", 28'h0000015, result_out)
    accumulate_on = 1'b0;
    tick(14);
    `CHK("acc_load", 28'h000001b, result_out)
  endtask : t_hold_acc
  // a reserved address must not reset; a control write must, keeping coefficients
  task automatic t_cfg_reset();
    fork
      i_dfir_host.write(9'h055, 10'h3ff, 3);
      watch_zero(seen);
    join
    `CHK("reserved", 1'b0, seen)
    fork
      i_dfir_host.write(9'h001, 10'h000, 4);
      watch_zero(seen);
    join
    `CHK("int_reset", 1'b1, seen)
    tick(14);
    `CHK("coef_kept", 28'h000001b, result_out)
  endtask : t_cfg_reset

  // ***************************************************************
  // main sequence and watchdog
  // ***************************************************************
  initial begin
    tick(3);
    rst = 1'b0;
    `CHK("reset_out", 28'h0000000, result_out)
    t_enables();
    t_setup();
    t_combine();
    t_paths();
    t_hold_acc();
    t_cfg_reset();
    conclude();
  end
  // the whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
